/* hdl/pts_tx_ctrl.sv */
// Transmit control of the 24-bit parallel-to-serial link with AXI4-Lite registers
//
// Overview of operation
// R1 - One 24-bit parallel word is taken per cycle of the parallel clock.
// R2 - The source ties unused parallel data inputs low and never lets them float.
// R3 - Edge select high captures on the rising parallel clock edge, low on the falling edge.
// R4 - Sleep (active low) puts the serial output in high impedance and shuts the PLL off.
// R5 - With sleep released the transmitter runs normally.
// R6 - Output enable low puts the serial output in high impedance while the PLL stays locked.
// R7 - Output enable high drives the differential serial output.
// R8 - Pre-emphasis is applied when its select is low and omitted when it is high.
// R9 - The system keeps swing select low except for long cables, where high gives the large swing.
// R10 - The three reserved configuration inputs are held low by the system.
// R11 - After the output has been in high impedance the receiver must resynchronise first.
// R12 - Each captured word goes out as one DC-balanced frame with embedded clock bits.
`include "pts_params.svh"
`timescale 1ns/1ps
`default_nettype none
module pts_tx_ctrl #(
	parameter int LOCK_CYCLES = `PTS_PLL_LOCK_CYCLES,
	parameter int FIFO_DEPTH = `PTS_FIFO_DEPTH
) (
	// Clock, reset, enable
	input wire logic clock_in,
	input wire logic resetn_in,
	input wire logic clk_en_in,
	// AXI4-Lite write
	input wire logic [7:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	// Parallel side
	input wire logic par_clk_in,
	input wire logic [`PTS_DATA_W-1:0] par_data_in,
	// Serial side
	output logic ser_p_out,
	output logic ser_n_out,
	output logic ser_oe_out,
	output logic pre_emph_out,
	output logic swing_hi_out
);
	localparam int CW = $clog2(LOCK_CYCLES + 1);
	localparam int LW = $clog2(FIFO_DEPTH) + 1;
	localparam int FB = `PTS_FRAME_BITS;

	// Register bus state
	logic awready_r, wready_r, aw_got_r, w_got_r, bvalid_r, arready_r, rvalid_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r;
	logic [7:0] ctrl_r;
	logic ovf_r;
	logic [31:0] frames_r;
	// Capture, PLL and serializer state
	logic par_clk_prev_r;
	logic cap_valid_r;
	pts_pkg::pts_word_type cap_data_r;
	logic [CW-1:0] lock_cnt_r;
	logic pll_locked_r;
	pts_pkg::pts_ser_state_type ser_state_r;
	logic [FB-1:0] shift_r;
	logic [4:0] bitcnt_r;
	logic disp_pos_r;
	logic ser_bit_r, ser_p_r, ser_n_r, ser_oe_r, pre_emph_r, swing_r;

	// Control fields
	wire sleep_n = ctrl_r[`PTS_CTRL_SLEEP_N];
	wire out_en = ctrl_r[`PTS_CTRL_OUT_EN];
	wire edge_sel = ctrl_r[`PTS_CTRL_EDGE_SEL];
	wire pre_off = ctrl_r[`PTS_CTRL_PRE_OFF];
	wire resv_viol = |ctrl_r[`PTS_CTRL_RESV_LSB +: 3]; // [R10]

	// Write channel decode
	wire aw_take = s_axi_awvalid_in && awready_r;
	wire w_take = s_axi_wvalid_in && wready_r;
	wire wr_fire = aw_got_r && w_got_r && !bvalid_r;
	wire b_done = bvalid_r && s_axi_bready_in;
	wire wr_ctrl = wr_fire && (awaddr_r == `PTS_ADDR_CTRL) && wstrb_r[0];
	wire wr_ok = (awaddr_r == `PTS_ADDR_CTRL) || (awaddr_r == `PTS_ADDR_STATUS);
	wire ovf_clr = wr_fire && (awaddr_r == `PTS_ADDR_STATUS) && wstrb_r[0] && wdata_r[`PTS_ST_OVF];

	// Read channel decode
	wire ar_take = s_axi_arvalid_in && arready_r;
	wire r_done = rvalid_r && s_axi_rready_in;
	wire [LW-1:0] fifo_level;
	wire [31:0] status_word = {24'h00_0000, 4'(fifo_level), 1'b0, resv_viol, ovf_r, pll_locked_r};
	wire rd_ctrl = (s_axi_araddr_in == `PTS_ADDR_CTRL);
	wire rd_stat = (s_axi_araddr_in == `PTS_ADDR_STATUS);
	wire rd_frm = (s_axi_araddr_in == `PTS_ADDR_FRAMES);
	wire [31:0] rd_data = rd_ctrl ? {24'h00_0000, ctrl_r} : rd_stat ? status_word : rd_frm ? frames_r : 32'h0000_0000;
	wire rd_ok = rd_ctrl || rd_stat || rd_frm;

	// Parallel clock edge detection and capture
	wire par_rise = par_clk_in && !par_clk_prev_r;
	wire par_fall = !par_clk_in && par_clk_prev_r;
	wire cap_edge = edge_sel ? par_rise : par_fall; // [R3]
	wire accept = cap_edge && pll_locked_r && sleep_n; // [R1]
	wire fifo_in_ready;
	wire ovf_set = accept && cap_valid_r && !fifo_in_ready;

	// FIFO drain and frame build
	wire fifo_out_valid;
	pts_pkg::pts_word_type fifo_data;
	wire fifo_out_ready = (ser_state_r == pts_pkg::PTS_IDLE) && pll_locked_r && sleep_n;
	wire load = fifo_out_valid && fifo_out_ready;

	function automatic logic [4:0] ones_of(input pts_pkg::pts_word_type d);
		logic [4:0] n;
		n = '0;
		for (int i = 0; i < `PTS_DATA_W; i++)
			n = n + 5'(d[i]);
		return n;
	endfunction

	wire [4:0] data_ones = ones_of(fifo_data);
	wire [4:0] half = 5'(`PTS_HALF_ONES);
	wire invert = (data_ones > half && disp_pos_r) || (data_ones < half && !disp_pos_r); // [R12]
	wire [4:0] sent_ones = invert ? 5'(`PTS_DATA_W) - data_ones : data_ones;
	wire [FB-1:0] frame = {1'b1, invert, invert ? ~fifo_data : fifo_data, 1'b0}; // [R12]
	wire sending = (ser_state_r == pts_pkg::PTS_SEND);
	wire last_bit = sending && (bitcnt_r == 5'h1);

	// Serial line next values
	wire ser_bit_nxt = !sleep_n ? 1'b0 : load ? frame[FB-1] : sending ? shift_r[FB-1] : 1'b0;
	wire ser_oe_nxt = sleep_n && out_en && pll_locked_r; // [R4] [R6] [R7]
	wire pre_emph_nxt = !pre_off && ser_oe_nxt && (ser_bit_nxt != ser_bit_r); // [R8]

	pts_fifo #(
		.WIDTH(`PTS_DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clock_in(clock_in),
		.resetn_in(resetn_in),
		.clk_en_in(clk_en_in),
		.flush_in(!sleep_n),
		.in_valid_in(cap_valid_r),
		.in_ready_out(fifo_in_ready),
		.in_data_in(cap_data_r),
		.out_valid_out(fifo_out_valid),
		.out_ready_in(fifo_out_ready),
		.out_data_out(fifo_data),
		.level_out(fifo_level)
	);

	// AXI4-Lite write path
	always_ff @(posedge clock_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= `PTS_RESP_OKAY;
			awaddr_r <= '0;
			wdata_r <= '0;
			wstrb_r <= '0;
		end
		else if (clk_en_in)
		begin
			if (aw_take)
			begin
				awaddr_r <= s_axi_awaddr_in;
				aw_got_r <= 1'b1;
				awready_r <= 1'b0;
			end
			else if (wr_fire)
				aw_got_r <= 1'b0;
			if (w_take)
			begin
				wdata_r <= s_axi_wdata_in;
				wstrb_r <= s_axi_wstrb_in;
				w_got_r <= 1'b1;
				wready_r <= 1'b0;
			end
			else if (wr_fire)
				w_got_r <= 1'b0;
			if (wr_fire)
			begin
				bvalid_r <= 1'b1;
				bresp_r <= wr_ok ? `PTS_RESP_OKAY : `PTS_RESP_SLVERR;
			end
			else if (b_done)
			begin
				bvalid_r <= 1'b0;
				awready_r <= 1'b1;
				wready_r <= 1'b1;
			end
		end
	end

	// AXI4-Lite read path
	always_ff @(posedge clock_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= `PTS_RESP_OKAY;
		end
		else if (clk_en_in)
		begin
			if (ar_take)
			begin
				arready_r <= 1'b0;
				rvalid_r <= 1'b1;
				rdata_r <= rd_data;
				rresp_r <= rd_ok ? `PTS_RESP_OKAY : `PTS_RESP_SLVERR;
			end
			else if (r_done)
			begin
				rvalid_r <= 1'b0;
				arready_r <= 1'b1;
			end
		end
	end

	// Control register and sticky overflow, set wins over clear
	always_ff @(posedge clock_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			ctrl_r <= `PTS_CTRL_RESET;
			ovf_r <= 1'b0;
		end
		else if (clk_en_in)
		begin
			if (wr_ctrl)
				ctrl_r <= wdata_r[7:0];
			ovf_r <= ovf_set || (ovf_r && !ovf_clr);
		end
	end

	// PLL lock model: shut down in sleep, locks after the lock time
	always_ff @(posedge clock_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			lock_cnt_r <= '0;
			pll_locked_r <= 1'b0;
		end
		else if (clk_en_in)
		begin
			if (!sleep_n)
			begin
				lock_cnt_r <= '0; // [R4]
				pll_locked_r <= 1'b0;
			end
			else if (!pll_locked_r)
			begin
				lock_cnt_r <= lock_cnt_r + 1'b1; // [R5]
				pll_locked_r <= (lock_cnt_r == CW'(LOCK_CYCLES - 1));
			end
		end
	end

	// Capture holds its word until the FIFO takes it, the next capture overwrites it or sleep drops it
	always_ff @(posedge clock_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			par_clk_prev_r <= 1'b0;
			cap_valid_r <= 1'b0;
			cap_data_r <= '0;
		end
		else if (clk_en_in)
		begin
			par_clk_prev_r <= par_clk_in;
			if (!sleep_n)
				cap_valid_r <= 1'b0;
			else if (accept)
			begin
				cap_valid_r <= 1'b1; // [R1] [R3]
				cap_data_r <= par_data_in;
			end
			else if (fifo_in_ready)
				cap_valid_r <= 1'b0;
		end
	end

	// Serializer: start bit, balance flag, 24 data bits, stop bit
	always_ff @(posedge clock_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			ser_state_r <= pts_pkg::PTS_IDLE;
			shift_r <= '0;
			bitcnt_r <= '0;
			disp_pos_r <= 1'b0;
			frames_r <= '0;
		end
		else if (clk_en_in)
		begin
			if (!sleep_n)
				ser_state_r <= pts_pkg::PTS_IDLE;
			else if (load)
			begin
				ser_state_r <= pts_pkg::PTS_SEND; // [R12]
				shift_r <= {frame[FB-2:0], 1'b0};
				bitcnt_r <= 5'(FB - 1);
				frames_r <= frames_r + 32'h0000_0001;
				if (sent_ones != half)
					disp_pos_r <= (sent_ones > half);
			end
			else if (sending)
			begin
				shift_r <= {shift_r[FB-2:0], 1'b0};
				bitcnt_r <= bitcnt_r - 5'h1;
				if (last_bit)
					ser_state_r <= pts_pkg::PTS_IDLE;
			end
		end
	end

	// Registered line drivers
	always_ff @(posedge clock_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			ser_bit_r <= 1'b0;
			ser_p_r <= 1'b0;
			ser_n_r <= 1'b0;
			ser_oe_r <= 1'b0;
			pre_emph_r <= 1'b0;
			swing_r <= 1'b0;
		end
		else if (clk_en_in)
		begin
			ser_bit_r <= ser_bit_nxt;
			ser_p_r <= ser_oe_nxt && ser_bit_nxt; // [R7]
			ser_n_r <= ser_oe_nxt && !ser_bit_nxt;
			ser_oe_r <= ser_oe_nxt;
			pre_emph_r <= pre_emph_nxt;
			swing_r <= ctrl_r[`PTS_CTRL_SWING]; // [R9]
		end
	end

	assign s_axi_awready_out = awready_r;
	assign s_axi_wready_out = wready_r;
	assign s_axi_bvalid_out = bvalid_r;
	assign s_axi_bresp_out = bresp_r;
	assign s_axi_arready_out = arready_r;
	assign s_axi_rvalid_out = rvalid_r;
	assign s_axi_rdata_out = rdata_r;
	assign s_axi_rresp_out = rresp_r;
	assign ser_p_out = ser_p_r;
	assign ser_n_out = ser_n_r;
	assign ser_oe_out = ser_oe_r;
	assign pre_emph_out = pre_emph_r;
	assign swing_hi_out = swing_r;

	// Checks
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!resetn_in);

	AST_CAPTURE_DATA: assert property (clk_en_in && accept |=> cap_valid_r && cap_data_r == $past(par_data_in)) // [R1]
		else $error("captured word differs from parallel input");
	AST_CAPTURE_RISE: assert property (clk_en_in && edge_sel && par_rise && pll_locked_r && sleep_n |=> cap_valid_r) // [R3]
		else $error("rising edge not captured");
	AST_NO_WRONG_EDGE: assert property (clk_en_in && !edge_sel && par_rise && !cap_valid_r |=> !cap_valid_r) // [R3]
		else $error("rising edge captured while falling edge selected");
	AST_SLEEP_HIZ: assert property (clk_en_in && !sleep_n |=> !ser_oe_r && !pll_locked_r) // [R4]
		else $error("output driven or PLL locked in sleep");
	AST_WAKE_LOCK: assert property ($rose(pll_locked_r) |-> $past(lock_cnt_r) == CW'(LOCK_CYCLES - 1)) // [R5]
		else $error("PLL locked before the lock time");
	AST_OE_OFF_KEEP_LOCK: assert property (clk_en_in && sleep_n && !out_en && pll_locked_r |=> !ser_oe_r && pll_locked_r) // [R6]
		else $error("output enable low must tristate and keep lock");
	AST_OE_ON: assert property (clk_en_in && sleep_n && out_en && pll_locked_r |=> ser_oe_r && (ser_p_r != ser_n_r)) // [R7]
		else $error("enabled output not driven differentially");
	AST_PRE_OFF: assert property (clk_en_in && pre_off |=> !pre_emph_r) // [R8]
		else $error("pre-emphasis active while disabled");
	AST_FRAME_START: assert property (clk_en_in && load && sleep_n |=> ser_bit_r && bitcnt_r == 5'(FB - 1)) // [R12]
		else $error("frame does not open with its start bit");
	AST_FRAME_END: assert property (clk_en_in && sleep_n && last_bit |=> !ser_bit_r && ser_state_r == pts_pkg::PTS_IDLE) // [R12]
		else $error("frame does not close with its stop bit");

	COV_FRAME: cover property (clk_en_in && load);
	COV_OVERFLOW: cover property (clk_en_in && ovf_set);
	COV_FALL_CAPTURE: cover property (clk_en_in && !edge_sel && par_fall && accept);
	COV_PRE_EMPH: cover property (pre_emph_r);
endmodule // pts_tx_ctrl
`default_nettype wire

/* hdl/pts_params.svh */
// Offsets, field positions, reset values and timing counts of the serial transmit block
`ifndef PTS_PARAMS_SVH
`define PTS_PARAMS_SVH
`define PTS_DATA_W 24
`define PTS_FIFO_DEPTH 8
`define PTS_FRAME_BITS 27
`define PTS_HALF_ONES 12
`define PTS_CLK_PERIOD_NS 100
`define PTS_PLL_LOCK_NS 10000
`define PTS_PLL_LOCK_CYCLES ((`PTS_PLL_LOCK_NS + `PTS_CLK_PERIOD_NS - 1) / `PTS_CLK_PERIOD_NS)
`define PTS_ADDR_CTRL 8'h00
`define PTS_ADDR_STATUS 8'h04
`define PTS_ADDR_FRAMES 8'h08
`define PTS_CTRL_RESET 8'h00
`define PTS_CTRL_SLEEP_N 0
`define PTS_CTRL_OUT_EN 1
`define PTS_CTRL_EDGE_SEL 2
`define PTS_CTRL_PRE_OFF 3
`define PTS_CTRL_SWING 4
`define PTS_CTRL_RESV_LSB 5
`define PTS_ST_LOCKED 0
`define PTS_ST_OVF 1
`define PTS_ST_RESV 2
`define PTS_ST_LEVEL_LSB 4
`define PTS_RESP_OKAY 2'h0
`define PTS_RESP_SLVERR 2'h2
`endif

/* hdl/pts_pkg.sv */
// Types shared by the serial transmit block
package pts_pkg;
	typedef enum logic {PTS_IDLE, PTS_SEND} pts_ser_state_type;
	typedef logic [23:0] pts_word_type;
endpackage

/* hdl/pts_fifo.sv */
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module pts_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 8
) (
	// Clock and control
	input wire logic clock_in,
	input wire logic resetn_in,
	input wire logic clk_en_in,
	input wire logic flush_in,
	// Fill side
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	// Drain side
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out,
	output logic [$clog2(DEPTH):0] level_out
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0] wr_ptr_r;
	logic [AW:0] rd_ptr_r;
	logic push;
	logic pop;
	assign level_out = wr_ptr_r - rd_ptr_r;
	assign in_ready_out = (level_out != (AW+1)'(DEPTH));
	assign out_valid_out = (level_out != '0);
	assign out_data_out = mem_r[rd_ptr_r[AW-1:0]];
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;
	always_ff @(posedge clock_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end
		else if (clk_en_in)
		begin
			if (flush_in)
			begin
				wr_ptr_r <= '0;
				rd_ptr_r <= '0;
			end
			else
			begin
				if (push)
					wr_ptr_r <= wr_ptr_r + 1'b1;
				if (pop)
					rd_ptr_r <= rd_ptr_r + 1'b1;
			end
		end
	end
	always_ff @(posedge clock_in)
	begin
		if (clk_en_in && push && !flush_in)
			mem_r[wr_ptr_r[AW-1:0]] <= in_data_in;
	end
endmodule // pts_fifo
`default_nettype wire

/* tb/pts_link_partner.sv */
// Parallel word source and serial frame receiver at the far side of the transmit block
`timescale 1ns/1ps
`default_nettype none
module pts_link_partner (
	// Clock
	input wire logic clock_in,
	// Parallel source
	output logic par_clk_out,
	output logic [23:0] par_data_out,
	// Serial receiver
	input wire logic ser_p_in,
	input wire logic ser_n_in,
	input wire logic ser_oe_in,
	output logic [23:0] rx_word_out,
	output logic rx_flag_out,
	output logic [31:0] rx_count_out,
	output logic [31:0] rx_err_out
);
	logic [25:0] sh;
	int bit_cnt;
	initial
	begin
		par_clk_out = 1'b0;
		par_data_out = 24'h00_0000;
		rx_word_out = 24'h00_0000;
		rx_flag_out = 1'b0;
		rx_count_out = 32'h0000_0000;
		rx_err_out = 32'h0000_0000;
		bit_cnt = 0;
	end
	// Decoy word on the other edge, true word across the selected one, inverse once hold is over
	task automatic send(input logic [23:0] w, input logic rise);
		@(posedge clock_in);
		par_clk_out <= ~rise;
		par_data_out <= ~w;
		@(posedge clock_in);
		par_data_out <= w;
		repeat (2) @(posedge clock_in);
		par_clk_out <= rise;
		repeat (2) @(posedge clock_in);
		par_data_out <= ~w;
	endtask
	// Lock is lost whenever the line is not driven; a new start bit resynchronises
	always @(posedge clock_in)
	begin
		if (ser_oe_in !== 1'b1)
			bit_cnt <= 0;
		else
		begin
			if (ser_n_in !== ~ser_p_in)
				rx_err_out <= rx_err_out + 1;
			if (bit_cnt == 0 && ser_p_in === 1'b1)
			begin
				sh <= 26'h000_0001;
				bit_cnt <= 1;
			end
			else if (bit_cnt == 26)
			begin
				rx_flag_out <= sh[24];
				rx_word_out <= sh[24] ? ~sh[23:0] : sh[23:0];
				rx_count_out <= rx_count_out + 1;
				if (ser_p_in !== 1'b0)
					rx_err_out <= rx_err_out + 1;
				bit_cnt <= 0;
			end
			else if (bit_cnt != 0)
			begin
				sh <= {sh[24:0], ser_p_in};
				bit_cnt <= bit_cnt + 1;
			end
		end
	end
endmodule // pts_link_partner
`default_nettype wire

/* tb/pts_tx_ctrl_tb_top.sv */
// Self-checking bench for the serial transmit block
`include "pts_params.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
	$display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module pts_tx_ctrl_tb_top;
	logic clock_in = 1'b0;
	logic resetn_in = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000, rd;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, f1;
	logic [1:0] rs;
	wire logic awready, wready, bvalid, arready, rvalid, par_clk, ser_p, ser_n, ser_oe, pre_emph, swing_hi, rx_flag;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata, rx_count, rx_err;
	wire logic [23:0] par_data, rx_word;
	int fail_count = 0, cmp_count = 0, pe_cnt = 0, frames = 0, i;
	always #50 clock_in = ~clock_in;
	always @(posedge clock_in) if (pre_emph === 1'b1) pe_cnt++;
	pts_tx_ctrl #(.LOCK_CYCLES(4), .FIFO_DEPTH(8)) dut (
		.clock_in(clock_in), .resetn_in(resetn_in), .clk_en_in(1'b1),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'h1), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
		.s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
		.par_clk_in(par_clk), .par_data_in(par_data), .ser_p_out(ser_p), .ser_n_out(ser_n),
		.ser_oe_out(ser_oe), .pre_emph_out(pre_emph), .swing_hi_out(swing_hi));
	pts_link_partner link (.clock_in(clock_in), .par_clk_out(par_clk), .par_data_out(par_data),
		.ser_p_in(ser_p), .ser_n_in(ser_n), .ser_oe_in(ser_oe), .rx_word_out(rx_word),
		.rx_flag_out(rx_flag), .rx_count_out(rx_count), .rx_err_out(rx_err));
	task automatic results;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clock_in);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge clock_in);
			awvalid <= awvalid & ~(awready === 1'b1);
			wvalid <= wvalid & ~(wready === 1'b1);
			if (bvalid === 1'b1)
				break;
		end
		rs = bresp;
		bready <= 1'b0;
		if (n == 50)
		begin
			fail_count++;
			results;
		end
	endtask
	task automatic axi_rd(input logic [7:0] a);
		int n;
		@(posedge clock_in);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge clock_in);
			arvalid <= arvalid & ~(arready === 1'b1);
			if (rvalid === 1'b1)
				break;
		end
		rd = rdata;
		rs = rresp;
		rready <= 1'b0;
		if (n == 50)
		begin
			fail_count++;
			results;
		end
	endtask
	// Reserved configuration bits always written low
	task automatic ctrl(input logic [7:0] v);
		axi_wr(`PTS_ADDR_CTRL, {24'h00_0000, v & 8'h1f});
		`CHK(rs, `PTS_RESP_OKAY)
		repeat (3) @(negedge clock_in);
	endtask
	task automatic xfer(input logic [23:0] w, input logic rise, input logic exp_rx);
		int n;
		logic [31:0] c0;
		c0 = rx_count;
		link.send(w, rise);
		for (n = 0; n < 80 && rx_count === c0; n++)
			@(posedge clock_in);
		if (exp_rx && n == 80)
		begin
			fail_count++;
			results;
		end
		if (exp_rx)
		begin
			`CHK(rx_count, c0 + 32'h0000_0001)
			`CHK(rx_word, w)
		end
		else
			`CHK(rx_count, c0)
	endtask
	task automatic s_reset;
		`CHK({awready, wready, arready, bvalid, rvalid, ser_oe}, 6'h38)
		axi_rd(`PTS_ADDR_CTRL);
		`CHK(rd, 32'h0000_0000)
		axi_rd(`PTS_ADDR_STATUS);
		`CHK(rd[0], 1'b0)
		xfer(24'h13_579b, 1'b1, 1'b0);
		`CHK(ser_oe, 1'b0)
	endtask
	task automatic s_run;
		ctrl(8'h07);
		for (i = 0; i < 20 && rd[0] !== 1'b1; i++)
			axi_rd(`PTS_ADDR_STATUS);
		`CHK(rd[0], 1'b1)
		`CHK(ser_oe, 1'b1)
		xfer(24'hff_ffff, 1'b1, 1'b1);
		f1 = rx_flag;
		xfer(24'hff_ffff, 1'b1, 1'b1);
		`CHK(rx_flag, ~f1)
		xfer(24'h12_3456, 1'b1, 1'b1);
		frames += 3;
	endtask
	task automatic s_fall_pre;
		ctrl(8'h13);
		`CHK(swing_hi, 1'b1)
		ctrl(8'h03);
		`CHK(swing_hi, 1'b0)
		xfer(24'h67_89ab, 1'b0, 1'b1);
		pe_cnt = 0;
		xfer(24'h5a_5a5a, 1'b0, 1'b1);
		`CHK(pe_cnt != 0, 1'b1)
		ctrl(8'h0b);
		pe_cnt = 0;
		xfer(24'ha5_a5a5, 1'b0, 1'b1);
		`CHK(pe_cnt, 0)
		frames += 3;
	endtask
	task automatic s_oe_off;
		ctrl(8'h01);
		`CHK(ser_oe, 1'b0)
		axi_rd(`PTS_ADDR_STATUS);
		`CHK(rd[0], 1'b1)
		xfer(24'h11_1111, 1'b0, 1'b0);
		ctrl(8'h03);
		`CHK(ser_oe, 1'b1)
		xfer(24'h22_2222, 1'b0, 1'b1);
		frames += 2;
	endtask
	task automatic s_regs;
		axi_rd(`PTS_ADDR_FRAMES);
		`CHK(rd, 32'(frames))
		axi_wr(`PTS_ADDR_FRAMES, 32'h0000_0000);
		`CHK(rs, `PTS_RESP_SLVERR)
		axi_wr(8'h0c, 32'h0000_00ff);
		`CHK(rs, `PTS_RESP_SLVERR)
		axi_rd(8'h0c);
		`CHK({rd, rs}, {32'h0000_0000, `PTS_RESP_SLVERR})
		axi_rd(`PTS_ADDR_CTRL);
		`CHK(rd, 32'h0000_0003)
	endtask
	task automatic s_ovf;
		for (i = 0; i < 16; i++)
			link.send(24'(i), 1'b0);
		axi_rd(`PTS_ADDR_STATUS);
		`CHK(rd[7:4], 4'h8)
		`CHK(rd[1], 1'b1)
		axi_wr(`PTS_ADDR_STATUS, 32'h0000_0002);
		axi_rd(`PTS_ADDR_STATUS);
		`CHK(rd[1], 1'b0)
		ctrl(8'h00);
		`CHK(ser_oe, 1'b0)
		axi_rd(`PTS_ADDR_STATUS);
		`CHK({rd[7:4], rd[0]}, 5'h00)
		`CHK(rx_err, 32'h0000_0000)
	endtask
	initial
	begin
		repeat (6) @(posedge clock_in);
		resetn_in <= 1'b1;
		@(negedge clock_in);
		s_reset;
		s_run;
		s_fall_pre;
		s_oe_off;
		s_regs;
		s_ovf;
		results;
	end
endmodule // pts_tx_ctrl_tb_top
`default_nettype wire
